// ===== rtl/ddr_burst2_defs.svh
`ifndef DDR_BURST2_DEFS_SVH
`define DDR_BURST2_DEFS_SVH

// Array geometry, wide variant; set DATA_W to 18 for the narrow variant
`define ADDR_W     22
`define DATA_W     36
`define LANE_W     9

// Pin levels
`define SEL_ACTIVE 1'b0
`define MASK_WRITE 1'b0

`endif

// ===== rtl/ddr_burst2_pkg.sv
package ddr_burst2_pkg;
`include "ddr_burst2_defs.svh"

   // Which access the current main clock edge belongs to
   typedef enum logic {
      SLOT_READ,
      SLOT_WRITE
   } slot_t;

   // Read in flight: address and the burst already fetched
   typedef struct packed {
      logic                      valid;
      logic [`ADDR_W-1:0]        addr;
      logic [2*`DATA_W-1:0]      data;
   } rd_stage_t;

   // Write waiting for its second word
   typedef struct packed {
      logic                      valid;
      logic [`ADDR_W-1:0]        addr;
      logic [`DATA_W-1:0]        lo;
      logic [`DATA_W/`LANE_W-1:0] mask_lo;
   } wr_stage_t;

endpackage

// ===== rtl/sync_level.sv
`timescale 1ns/1ps
module sync_level #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta;

   // Two-stage capture; meta feeds q alone
   always_ff @(posedge clk) begin
      meta <= d;
      q    <= meta;
   end

endmodule

// ===== rtl/ddr_out_merge.sv
`timescale 1ns/1ps
module ddr_out_merge #(
   parameter int W = 36
) (
   input  wire logic         clk_rise,
   input  wire logic         clk_comp,
   input  wire logic         run,
   input  wire logic         load_rise,
   input  wire logic [W-1:0] d_rise,
   input  wire logic         load_comp,
   input  wire logic [W-1:0] d_comp,
   output logic      [W-1:0] q
);

   logic [W-1:0] half_rise;
   logic [W-1:0] half_comp;

   // Rising edge of true clock: first word of a burst
   always_ff @(posedge clk_rise) begin
      if (!run) begin
         half_rise <= '0;
      end else if (load_rise) begin
         half_rise <= d_rise ^ half_comp;
      end
   end

   // Rising edge of complementary clock: second word
   always_ff @(posedge clk_comp) begin
      if (!run) begin
         half_comp <= '0;
      end else if (load_comp) begin
         half_comp <= d_comp ^ half_rise;
      end
   end

   // Each half holds the word xor the other half, so no gating of clocks
   assign q = half_rise ^ half_comp;

endmodule

// ===== rtl/ddr_burst2_sram_port.sv
`timescale 1ns/1ps
`include "ddr_burst2_defs.svh"

module ddr_burst2_sram_port
   import ddr_burst2_pkg::*;
#(
   parameter int MEM_ADDR_W = `ADDR_W
) (
   input  wire logic                ref_clk,
   input  wire logic                rstn,
   input  wire logic                k_clk,
   input  wire logic                k_clk_n,
   input  wire logic                read_port_select_n,
   input  wire logic                write_port_select_n,
   input  wire logic [`ADDR_W-1:0]  addr,
   input  wire logic [`DATA_W-1:0]  write_data,
   input  wire logic [`DATA_W/`LANE_W-1:0] byte_lane_write_mask,
   input  wire logic                pll_bypass_latency_pin,
   output logic      [`DATA_W-1:0]  read_data,
   output logic                     read_valid_flag,
   output logic      [1:0]          echo_strobe_pair
);

   localparam int DW    = `DATA_W;
   localparam int AW    = `ADDR_W;
   localparam int LANES = `DATA_W / `LANE_W;
   localparam int LW    = `LANE_W;

   // Reset release and pin levels
   logic                 run_req;
   logic                 k_run;
   logic                 lat_long;

   // Link-side state
   slot_t                slot;
   rd_stage_t            rd1;
   rd_stage_t            rd2;
   wr_stage_t            wr;
   logic [DW-1:0]        wd_hi;
   logic [LANES-1:0]     mask_hi;
   logic [DW-1:0]        hi_hold;
   logic                 launch_hi;
   logic                 echo_rise;
   logic                 echo_comp;

   // Combinational decisions
   logic                 rd_take;
   logic                 wr_take;
   logic                 launch;
   logic [2*DW-1:0]      launch_data;

   // Storage array: one entry holds the whole two-word burst
   logic [2*DW-1:0]      mem [0:(1<<MEM_ADDR_W)-1];

   // Array index from the low address bits
   function automatic logic [MEM_ADDR_W-1:0] idx(input logic [AW-1:0] a);
      idx = a[MEM_ADDR_W-1:0];
   endfunction

   // Merge new lanes over old ones; a mask bit at its write level writes
   function automatic logic [2*DW-1:0] merge(input logic [2*DW-1:0]    old_v,
                                             input logic [2*DW-1:0]    new_v,
                                             input logic [2*LANES-1:0] mask);
      logic [2*DW-1:0] res;
      res = old_v;
      for (int i = 0; i < 2*LANES; i++) begin
         if (mask[i] == `MASK_WRITE) begin
            res[i*LW +: LW] = new_v[i*LW +: LW];
         end
      end
      merge = res;
   endfunction

   // Pending write seen from the main clock domain
   function automatic logic [2*DW-1:0] pending_burst(input logic [2*DW-1:0] old_v);
      pending_burst = merge(old_v, {wd_hi, wr.lo}, {mask_hi, wr.mask_lo});
   endfunction

   // Reset level in the reference domain, carried to the link domain
   // Link logic resets only while its clock runs, so the true clock
   // must keep toggling through reset
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         run_req <= 1'b0;
      end else begin
         run_req <= 1'b1;
      end
   end

   sync_level #(
      .W (1)
   ) u_run_sync (
      .clk (k_clk),
      .d   (run_req),
      .q   (k_run)
   );

   // Latency pin is static but asynchronous to the link clock
   // Changing it with reads in flight gives undefined timing
   sync_level #(
      .W (1)
   ) u_lat_sync (
      .clk (k_clk),
      .d   (pll_bypass_latency_pin),
      .q   (lat_long)
   );

   // Slot alternation on the true clock
   // First running edge is a read slot; only a reset realigns the phase,
   // so the controller counts slots from the same release
   always_ff @(posedge k_clk) begin
      if (!k_run) begin
         slot <= SLOT_READ;
      end else if (slot == SLOT_READ) begin
         slot <= SLOT_WRITE;
      end else begin
         slot <= SLOT_READ;
      end
   end

   // Port accept decisions from the pins at the capturing edge
   // A select sampled outside its own slot is ignored
   assign rd_take = k_run && (slot == SLOT_READ)
                    && (read_port_select_n == `SEL_ACTIVE);
   assign wr_take = k_run && (slot == SLOT_WRITE)
                    && (write_port_select_n == `SEL_ACTIVE);

   // Read input register; burst fetched now, pending write folded in
   // The write taken one slot earlier commits at this same edge, so the
   // array still holds the old burst and the pending words merge over it
   always_ff @(posedge k_clk) begin
      if (!k_run) begin
         rd1 <= '0;
      end else begin
         rd1.valid <= rd_take;
         rd1.addr  <= addr;
         if (wr.valid && (idx(wr.addr) == idx(addr))) begin
            rd1.data <= pending_burst(mem[idx(addr)]);
         end else begin
            rd1.data <= mem[idx(addr)];
         end
      end
   end

   // Second read stage for the long latency
   // The short latency launches from the first stage instead
   always_ff @(posedge k_clk) begin
      if (!k_run) begin
         rd2 <= '0;
      end else begin
         rd2 <= rd1;
      end
   end

   // Write input register: address, first word and its lane mask
   always_ff @(posedge k_clk) begin
      if (!k_run) begin
         wr <= '0;
      end else begin
         wr.valid   <= wr_take;
         wr.addr    <= addr;
         wr.lo      <= write_data;
         wr.mask_lo <= byte_lane_write_mask;
      end
   end

   // Second write word on the complementary clock
   always_ff @(posedge k_clk_n) begin
      if (!k_run) begin
         wd_hi   <= '0;
         mask_hi <= '0;
      end else begin
         wd_hi   <= write_data;
         mask_hi <= byte_lane_write_mask;
      end
   end

   // Self-timed commit one cycle after the write is taken
   // A read taken at this edge sees the merge through the forward path
   always_ff @(posedge k_clk) begin
      if (k_run && wr.valid) begin
         mem[idx(wr.addr)] <= pending_burst(mem[idx(wr.addr)]);
      end
   end

   // Launch point chosen by the latency pin
   always_comb begin
      if (lat_long) begin
         launch      = rd2.valid;
         launch_data = rd2.data;
      end else begin
         launch      = rd1.valid;
         launch_data = rd1.data;
      end
   end

   // Output control on the true clock
   // Upper word waits half a period in hi_hold for the complementary edge
   always_ff @(posedge k_clk) begin
      if (!k_run) begin
         read_valid_flag <= 1'b0;
         hi_hold         <= '0;
         launch_hi       <= 1'b0;
      end else begin
         read_valid_flag <= launch;
         hi_hold         <= launch_data[2*DW-1:DW];
         launch_hi       <= launch;
      end
   end

   // Double-rate output register pair
   ddr_out_merge #(
      .W (DW)
   ) u_out (
      .clk_rise  (k_clk),
      .clk_comp  (k_clk_n),
      .run       (k_run),
      .load_rise (launch),
      .d_rise    (launch_data[DW-1:0]),
      .load_comp (launch_hi),
      .d_comp    (hi_hold),
      .q         (read_data)
   );

   // Echo strobes: each edge follows one clock's launch edge
   // Toggle strobes, not clock copies, so no clock gating is needed
   always_ff @(posedge k_clk) begin
      if (!k_run) begin
         echo_rise <= 1'b0;
      end else begin
         echo_rise <= ~echo_rise;
      end
   end

   always_ff @(posedge k_clk_n) begin
      if (!k_run) begin
         echo_comp <= 1'b0;
      end else begin
         echo_comp <= ~echo_comp;
      end
   end

   assign echo_strobe_pair = {echo_comp, echo_rise};

   // Checks on the true clock domain
   // All of them stand down while the link logic is held in reset
   default clocking cb @(posedge k_clk);
   endclocking
   default disable iff (!k_run);

   // Slots alternate every edge
   a_slot_alternate: assert property (
      $past(k_run) |-> (slot != $past(slot))
   ) else $error("slot did not alternate");

   // Long latency: valid two cycles after capture
   a_read_lat_long: assert property (
      (rd_take && lat_long) ##1 lat_long[*2] |-> !read_valid_flag ##1 read_valid_flag
   ) else $error("long latency read not on time");

   // Short latency: valid one cycle after capture
   a_read_lat_short: assert property (
      (rd_take && !lat_long) ##1 !lat_long |=> read_valid_flag
   ) else $error("short latency read not on time");

   // Deselected read port takes nothing
   a_read_ignored: assert property (
      (slot == SLOT_READ) && (read_port_select_n != `SEL_ACTIVE) |=> !rd1.valid
   ) else $error("read taken while deselected");

   // Deselected write port takes nothing
   a_write_ignored: assert property (
      (slot == SLOT_WRITE) && (write_port_select_n != `SEL_ACTIVE) |=> !wr.valid
   ) else $error("write taken while deselected");

   // First word of a write with all its lanes enabled lands in the array with no further action
   a_write_commit: assert property (
      wr_take && (byte_lane_write_mask == {LANES{`MASK_WRITE}}) |->
         ##2 (mem[idx($past(addr, 2))][DW-1:0] == $past(write_data, 2))
   ) else $error("write word not committed");

   // Valid lasts one period, data launched with it
   a_valid_single: assert property (
      read_valid_flag |=> !read_valid_flag
   ) else $error("read valid held too long");

   // Read taken next to a pending write is not blocked
   a_concurrent_ports: assert property (
      wr.valid && rd_take |=> rd1.valid && !wr.valid
   ) else $error("read blocked by pending write");

   // Read of a pending write returns its first word when that word writes all lanes
   a_pending_forward: assert property (
      rd_take && wr.valid && (idx(wr.addr) == idx(addr))
         && (wr.mask_lo == {LANES{`MASK_WRITE}}) |=> rd1.data[DW-1:0] == $past(wr.lo)
   ) else $error("pending write not forwarded");

   // Echo strobe runs on every edge
   a_echo_running: assert property (
      $past(k_run) |-> (echo_rise != $past(echo_rise))
   ) else $error("echo strobe stopped");

   // Complementary echo strobe toggles once per period
   a_echo_comp_running: assert property (
      $past(k_run) |-> (echo_comp != $past(echo_comp))
   ) else $error("complementary echo strobe stopped");

   // Full pending burst lands whole in the array
   a_burst_commit: assert property (
      wr.valid && ({mask_hi, wr.mask_lo} == {2*LANES{`MASK_WRITE}}) |=>
         (mem[idx($past(wr.addr))] == $past({wd_hi, wr.lo}))
   ) else $error("write burst not committed");

   // No valid without a read taken in the last three slots
   a_no_idle_valid: assert property (
      !rd_take [*3] |=> !read_valid_flag
   ) else $error("read valid without a read");

   // Main scenarios
   c_read_long: cover property (rd_take && lat_long ##3 read_valid_flag);
   c_read_short: cover property (rd_take && !lat_long ##2 read_valid_flag);
   c_masked_write: cover property (wr_take
                                   && (byte_lane_write_mask != {LANES{`MASK_WRITE}}));
   c_write_then_read: cover property (wr_take ##1 (rd_take && wr.valid
                                        && (idx(wr.addr) == idx(addr))));
   c_back_to_back: cover property (rd_take ##1 wr_take ##1 rd_take);

endmodule

// ===== testbench/ctl_model.sv
`timescale 1ns/1ps
`include "ddr_burst2_defs.svh"
module ctl_model (
   input  wire logic                  k_clk,
   input  wire logic                  rvalid,
   output logic                       rd_sel_n,
   output logic                       wr_sel_n,
   output logic [`ADDR_W-1:0]         addr,
   output logic [`DATA_W-1:0]         wdata,
   output logic [`DATA_W/`LANE_W-1:0] wmask
);
   int                     kcnt = 0;
   bit                     rpar = 0;
   int                     qe[$];
   logic [2*`DATA_W-1:0]   qd[$];

   // Idle levels, both ports deselected
   initial begin
      rd_sel_n = 1'b1;
      wr_sel_n = 1'b1;
      addr = '0;
      wdata = '0;
      wmask = '1;
   end

   // Link rising edges seen so far
   always @(posedge k_clk) kcnt <= kcnt + 1;

   // Find the read slot phase from where valid lands
   task automatic align;
      @(negedge k_clk);
      rd_sel_n <= 1'b0;
      repeat (6) @(posedge k_clk);
      #2 rpar = kcnt[0] ~^ rvalid;
      @(negedge k_clk);
      rd_sel_n <= 1'b1;
   endtask

   // One read slot, then one write slot with its two words
   task automatic op(input logic rd, input logic [`ADDR_W-1:0] ra, input logic wr,
                     input logic [`ADDR_W-1:0] wa, input logic [71:0] wd,
                     input logic [7:0] m, input logic [71:0] ex, input int lat);
      if (k_clk) @(negedge k_clk);
      while (kcnt[0] == rpar) @(negedge k_clk);
      rd_sel_n <= ~rd;
      addr <= ra;
      if (rd) begin
         qe.push_back(kcnt + 1 + lat);
         qd.push_back(ex);
      end
      @(negedge k_clk);
      rd_sel_n <= 1'b1;
      wr_sel_n <= ~wr;
      addr <= wa;
      wdata <= wd[35:0];
      wmask <= m[3:0];
      @(posedge k_clk);
      wdata <= wd[71:36];
      wmask <= m[7:4];
      @(negedge k_clk);
      wr_sel_n <= 1'b1;
      wdata <= ~wdata; // Released lines show no stale word
   endtask
endmodule

// ===== testbench/tb_ddr_burst2_sram_port.sv
`timescale 1ns/1ps
`include "ddr_burst2_defs.svh"
module tb_ddr_burst2_sram_port;
   typedef struct packed {
      logic               rd;
      logic [`ADDR_W-1:0] ra;
      logic               wr;
      logic [`ADDR_W-1:0] wa;
      logic [71:0]        wd;
      logic [7:0]         m;
      logic [71:0]        ex;
   } row_t;
   logic                ref_clk, rstn, k_clk, k_clk_n, rd_sel_n, wr_sel_n;
   logic                pin, valid, e0, e1, due, chk_on;
   logic [`ADDR_W-1:0]  addr;
   logic [35:0]         wdata, rdata, w1;
   logic [3:0]          wmask;
   logic [1:0]          echo;
   int                  mismatches, checked, lat;
   // Read slot, write slot, and the burst that the read returns
   row_t                rows [8] = '{
      '{1'b0, 22'h010, 1'b1, 22'h010, {8{9'h0a5}}, 8'h00, 72'h0},
      '{1'b1, 22'h010, 1'b1, 22'h011, {8{9'h15a}}, 8'h00, {8{9'h0a5}}},
      '{1'b1, 22'h011, 1'b1, 22'h010, {8{9'h0f0}}, 8'h00, {8{9'h15a}}},
      '{1'b1, 22'h010, 1'b1, 22'h010, {8{9'h10f}}, 8'h5a, {8{9'h0f0}}},
      '{1'b1, 22'h010, 1'b0, 22'h011, {8{9'h033}}, 8'h00,
        {9'h10f, 9'h0f0, 9'h10f, 9'h0f0, 9'h0f0, 9'h10f, 9'h0f0, 9'h10f}},
      '{1'b1, 22'h011, 1'b1, 22'h212, {8{9'h1cc}}, 8'h00, {8{9'h15a}}},
      '{1'b1, 22'h012, 1'b0, 22'h012, {8{9'h0ff}}, 8'h00, {8{9'h1cc}}},
      '{1'b0, 22'h010, 1'b0, 22'h010, {8{9'h111}}, 8'h00, 72'h0}};

   ddr_burst2_sram_port #(.MEM_ADDR_W(8)) ddr_burst2_sram_port_i (
      .ref_clk(ref_clk), .rstn(rstn), .k_clk(k_clk), .k_clk_n(k_clk_n),
      .read_port_select_n(rd_sel_n), .write_port_select_n(wr_sel_n),
      .addr(addr), .write_data(wdata), .byte_lane_write_mask(wmask),
      .pll_bypass_latency_pin(pin), .read_data(rdata),
      .read_valid_flag(valid), .echo_strobe_pair(echo));
   ctl_model ctl_model_i (.k_clk(k_clk), .rvalid(valid), .rd_sel_n(rd_sel_n),
      .wr_sel_n(wr_sel_n), .addr(addr), .wdata(wdata), .wmask(wmask));

   assign k_clk_n = ~k_clk;
   // Reference clock
   initial begin
      ref_clk = 0;
      forever #25 ref_clk = ~ref_clk;
   end
   // Link clock, own phase
   initial begin
      k_clk = 0;
      #7;
      forever #16 k_clk = ~k_clk;
   end

   task automatic check(input logic bad, input string s);
      checked++;
      if (bad) begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, s);
      end
   endtask

   task automatic stop_test;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Issue one row; its read expects the row's burst, forwarded writes included
   task automatic go(input row_t r);
      ctl_model_i.op(r.rd, r.ra, r.wr, r.wa, r.wd, r.m, r.ex, lat);
   endtask

   task automatic start;
      repeat (4) @(posedge k_clk);
      ctl_model_i.align();
      repeat (4) @(posedge k_clk);
      @(negedge k_clk);
      chk_on = 1;
   endtask

   task automatic drain;
      repeat (4) @(posedge k_clk);
      check(ctl_model_i.qe.size() != 0, "reads lost");
      @(negedge k_clk);
   endtask

   // Read data, valid and rising echo
   always @(posedge k_clk) begin
      #2;
      if (chk_on) begin
         check(echo[0] === e0, "echo rise");
         if (ctl_model_i.qe.size() > 0 && ctl_model_i.qe[0] == ctl_model_i.kcnt) begin
            w1 = ctl_model_i.qd[0][71:36];
            check(valid !== 1'b1 || rdata !== ctl_model_i.qd[0][35:0], "word0");
            void'(ctl_model_i.qe.pop_front());
            void'(ctl_model_i.qd.pop_front());
            due = 1;
         end else check(valid !== 1'b0, "stray valid");
      end
      e0 = echo[0];
   end
   // Second word and complementary echo
   always @(negedge k_clk) begin
      #2;
      if (chk_on) check(echo[1] === e1, "echo fall");
      if (due) check(rdata !== w1, "word1");
      due = 0;
      e1 = echo[1];
   end

   // Watchdog
   initial begin
      #200000;
      mismatches++;
      stop_test();
   end

   initial begin
      rstn = 0;
      pin = 1;
      chk_on = 0;
      due = 0;
      mismatches = 0;
      checked = 0;
      lat = 2;
      repeat (12) @(negedge ref_clk);
      rstn = 1;
      start();
      foreach (rows[j]) go(rows[j]);
      drain();
      // Single-cycle latency
      @(negedge ref_clk);
      pin = 0;
      lat = 1;
      repeat (6) @(posedge k_clk);
      foreach (rows[j]) go(rows[j]);
      drain();
      // Reset in mid-run, then resume
      chk_on = 0;
      @(negedge ref_clk);
      rstn = 0;
      pin = 1;
      lat = 2;
      repeat (4) @(negedge ref_clk);
      check(valid !== 1'b0 || rdata !== '0 || echo !== 2'b00, "reset state");
      rstn = 1;
      start();
      foreach (rows[j]) go(rows[j]);
      drain();
      stop_test();
   end
endmodule
